// ==== verilog/spl_latch_driver.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "spl_defs.svh"

module spl_latch_driver (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // serial side from the host
  input wire logic shift_clock_i,
  input wire logic serial_data_i,
  // control strobes from the host
  input wire logic latch_load_strobe_i,
  input wire logic output_gate_i,
  // buffer flow control
  input wire logic shift_stall_i,
  output logic serial_ready_o,
  // cascade to the next device
  output logic serial_out_o,
  // parallel channels, bit 0 is the first channel
  output var spl_pkg::spl_word_type channel_output_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  spl_fifo_if #(.WIDTH(`SPL_FIFO_WIDTH)) bit_lnk (); // bit buffer link
  logic sclk_prev_r; // shift clock one cycle ago
  logic sclk_rise; // rising edge of the shift clock
  logic shift_fire; // one bit leaves the buffer into the chain
  spl_pkg::spl_word_type stage_r; // shift chain, bit 0 is stage one
  spl_pkg::spl_word_type stage_nxt; // chain after one shift
  spl_pkg::spl_word_type latch_r; // latch bank
  spl_pkg::spl_word_type latch_nxt; // latch bank next value
  spl_pkg::spl_word_type channel_nxt; // gated outputs next value
  logic serial_out_r; // cascade bit

  // ****************************************************************
  // shift clock edge detection
  // ****************************************************************
  // shift clock is sampled as a synchronous level; a rise is an edge.
  // the host spaces rises by at least SPL_MIN_EDGE_CYCLES, so one pop
  // per cycle drains the buffer long before the next bit arrives
  // history resets low, the idle level of the pin, so no false rise follows reset
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= shift_clock_i;
    end
  end

  assign sclk_rise = shift_clock_i && !sclk_prev_r;

  // ****************************************************************
  // serial bit buffer
  // ****************************************************************
  // each rise captures the serial input bit into the buffer while it has room
  assign bit_lnk.push_valid = sclk_rise;
  assign bit_lnk.push_data = serial_data_i;
  // drain unless the user stalls; stall lets the buffer really fill
  assign bit_lnk.pop_ready = !shift_stall_i;
  // room left for another bit, seen by the host side
  assign serial_ready_o = bit_lnk.push_ready;

  spl_fifo #(
    .WIDTH(`SPL_FIFO_WIDTH),
    .DEPTH(`SPL_FIFO_DEPTH)
  ) u_bit_fifo (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .lnk(bit_lnk)
  );

  // a pop moves one buffered bit into the chain; the buffer costs one cycle
  assign shift_fire = bit_lnk.pop_valid && bit_lnk.pop_ready;

  // ****************************************************************
  // shift chain
  // ****************************************************************
  // next chain value: new bit in at stage one, the rest move up
  always_comb begin
    stage_nxt = {stage_r[`SPL_STAGES-2:0], bit_lnk.pop_data[0]};
  end

  // the chain only looks at shift events, never at load or gate
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage_r <= `SPL_WORD_RST;
    end else if (shift_fire) begin
      stage_r <= stage_nxt;
    end
  end

  // cascade bit follows the last stage of the chain
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_out_r <= 1'b0;
    end else if (shift_fire) begin
      serial_out_r <= stage_nxt[`SPL_STAGES-1];
    end
  end

  assign serial_out_o = serial_out_r;

  // ****************************************************************
  // latch bank
  // ****************************************************************
  // load high: latches track the chain; load low: they hold
  always_comb begin
    if (latch_load_strobe_i) begin
      latch_nxt = stage_r;
    end else begin
      latch_nxt = latch_r;
    end
  end

  // latch register, refreshed every cycle from the chosen source
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      latch_r <= `SPL_WORD_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // ****************************************************************
  // output gating
  // ****************************************************************
  // gate low blanks every channel; gate high shows the latches,
  // bit 0 (channel one) from the stage one latch
  always_comb begin
    if (output_gate_i) begin
      channel_nxt = latch_r;
    end else begin
      channel_nxt = `SPL_WORD_RST;
    end
  end

  // outputs are registered so they never glitch between channels
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      channel_output_o <= `SPL_WORD_RST;
    end else begin
      channel_output_o <= channel_nxt;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // least cycles between two legal shift clock rises
  localparam int MIN_GAP = `SPL_MIN_EDGE_CYCLES;

  // chain, cascade, latch and gate behaviour, one edge at a time

  AST_SHIFT_ADVANCE: assert property (
    shift_fire |=> stage_r[0] == $past(bit_lnk.pop_data[0]))
    else $error("stage one did not take the serial bit");
  AST_CHAIN_LINK: assert property (
    shift_fire |=> stage_r[`SPL_STAGES-1:1] == $past(stage_r[`SPL_STAGES-2:0]))
    else $error("chain did not move by one stage");
  AST_CASCADE: assert property (
    shift_fire |=> serial_out_o == stage_r[`SPL_STAGES-1])
    else $error("cascade bit differs from last stage");
  AST_SHIFT_INDEP: assert property (
    !shift_fire |=> $stable(stage_r))
    else $error("chain moved without a shift event");
  AST_LATCH_PASS: assert property (
    latch_load_strobe_i |=> latch_r == $past(stage_r))
    else $error("latches did not follow the chain");
  AST_LATCH_HOLD: assert property (
    !latch_load_strobe_i |=> $stable(latch_r))
    else $error("latches changed while load was low");
  AST_GATE_LOW: assert property (
    !output_gate_i |=> channel_output_o == '0)
    else $error("outputs not low while gate low");
  AST_GATE_FOLLOW: assert property (
    output_gate_i |=> channel_output_o == $past(latch_r))
    else $error("outputs do not follow the latches");
  AST_FIRST_CHANNEL: assert property (
    (output_gate_i && latch_load_strobe_i) ##1 output_gate_i
      |=> channel_output_o[0] == $past(stage_r[0], 2))
    else $error("channel one not driven from stage one");
  AST_WIDTH: assert property (
    (output_gate_i && latch_load_strobe_i) ##1 output_gate_i
      |=> channel_output_o == $past(stage_r, 2))
    else $error("channel word does not match the chain");

  // a stalled buffer hands nothing to the chain
  AST_STALL_HOLDS: assert property (
    shift_stall_i |=> $stable(stage_r))
    else $error("chain moved while the buffer was stalled");
  AST_CASCADE_HOLD: assert property (
    !shift_fire |=> $stable(serial_out_o))
    else $error("cascade bit changed without a shift");

  // main scenarios reached
  COV_SHIFT: cover property (shift_fire ##1 !shift_fire [*2] ##1 shift_fire);
  COV_LOAD_SHOW: cover property (latch_load_strobe_i ##1 output_gate_i);
  COV_BLANK: cover property (output_gate_i ##1 !output_gate_i);
  COV_STALLED: cover property (shift_stall_i && !serial_ready_o);
  COV_GAP: cover property (sclk_rise ##MIN_GAP sclk_rise);

endmodule // spl_latch_driver

`default_nettype wire

// ==== verilog/spl_defs.svh ====
`ifndef SPL_DEFS_SVH
`define SPL_DEFS_SVH

// ****************************************************************
// widths and depths
// ****************************************************************
// number of shift stages, latches and channel outputs
`define SPL_STAGES 32
// serial bits buffered between the pin sampler and the shift chain
`define SPL_FIFO_DEPTH 4
// one serial bit per buffered word
`define SPL_FIFO_WIDTH 1

// ****************************************************************
// reset values
// ****************************************************************
// power-on content of shift chain, latches and outputs
`define SPL_WORD_RST 32'h0000_0000

// ****************************************************************
// timing
// ****************************************************************
// system clock rate in kHz
`define SPL_SYS_CLK_KHZ 200000
// fastest shift clock the host may apply, in kHz
`define SPL_SHIFT_FMAX_KHZ 8000
// least system cycles between two shift clock rising edges (round up)
`define SPL_MIN_EDGE_CYCLES \
  ((`SPL_SYS_CLK_KHZ + `SPL_SHIFT_FMAX_KHZ - 1) / `SPL_SHIFT_FMAX_KHZ)

`endif

// ==== verilog/spl_pkg.sv ====
`default_nettype none

`include "spl_defs.svh"

// ****************************************************************
// shared types
// ****************************************************************
package spl_pkg;
  // one word across all channels, bit 0 is channel one
  typedef logic [`SPL_STAGES-1:0] spl_word_type;
  // one buffered serial bit
  typedef logic [`SPL_FIFO_WIDTH-1:0] spl_bit_type;
endpackage

`default_nettype wire

// ==== verilog/spl_fifo_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// valid/ready link between the top and its bit buffer
// ****************************************************************
interface spl_fifo_if #(
  parameter int WIDTH = 1
);
  // filling side
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  // draining side
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;

  // the buffer itself
  modport buf_side (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );
  // the logic that fills and drains it
  modport user_side (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data
  );
endinterface

`default_nettype wire

// ==== verilog/spl_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "spl_defs.svh"

// ****************************************************************
// small synchronous fifo, width and depth as parameters
// ****************************************************************
module spl_fifo #(
  parameter int WIDTH = `SPL_FIFO_WIDTH,
  parameter int DEPTH = `SPL_FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // both handshake sides
  spl_fifo_if.buf_side lnk
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH]; // storage words
  logic [AW-1:0] wr_ptr_r; // next write slot
  logic [AW-1:0] rd_ptr_r; // oldest word
  logic [AW:0] count_r; // words held
  logic push_fire; // word taken
  logic pop_fire; // word given

  // honest flags straight from the count
  assign lnk.push_ready = (count_r != (AW+1)'(DEPTH)); // full only at depth words
  assign lnk.pop_valid = (count_r != '0);
  assign lnk.pop_data = mem_r[rd_ptr_r];
  assign push_fire = lnk.push_valid && lnk.push_ready;
  assign pop_fire = lnk.pop_valid && lnk.pop_ready;

  // storage write
  always_ff @(posedge sys_clk_i) begin
    if (push_fire) begin
      mem_r[wr_ptr_r] <= lnk.push_data;
    end
  end

  // pointers wrap at the depth
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push_fire) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop_fire) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_r <= '0;
    end else if (push_fire && !pop_fire) begin
      count_r <= count_r + 1'b1;
    end else if (pop_fire && !push_fire) begin
      count_r <= count_r - 1'b1;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_FIFO_BOUND: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    count_r <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  AST_FIFO_COUNT: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (push_fire && !pop_fire) |=> count_r == $past(count_r) + 1'b1)
    else $error("fifo count missed a push");

endmodule // spl_fifo

`default_nettype wire

// ==== verilog/spl_latch_driver_unused_guard.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb/spl_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// host controller: shift clock and serial bit source
// ****************************************************************
module spl_host_model (
  // clock
  input wire logic sys_clk_i,
  // serial side toward the device
  output logic shift_clock_o,
  output logic serial_data_o
);
  // idle: shift clock stands low outside transfers
  initial begin
    shift_clock_o = 1'b0;
    serial_data_o = 1'b0;
  end

  // one bit: rise with data valid, hold, fall, then stop showing the bit
  task automatic send_bit(input logic d, input int half);
    @(posedge sys_clk_i);
    shift_clock_o <= 1'b1;
    serial_data_o <= d;
    repeat (half) @(posedge sys_clk_i);
    shift_clock_o <= 1'b0;
    serial_data_o <= ~d; // hold over, line no longer carries the bit
    repeat (half - 1) @(posedge sys_clk_i); // period 2*half cycles
  endtask
endmodule // spl_host_model

`default_nettype wire

// ==== tb/spl_latch_driver_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module spl_latch_driver_test;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic shift_clock;
  logic serial_data;
  logic load = 1'b0; // latch load strobe
  logic gate = 1'b0; // output gate
  logic stall = 1'b0; // buffer drain stall
  logic serial_ready;
  logic serial_out;
  spl_pkg::spl_word_type chan;
  spl_pkg::spl_word_type exp_stage = 32'h0000_0000; // expected shift chain
  int err_count = 0;
  int checks = 0;

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  spl_host_model host (
    .sys_clk_i(sys_clk),
    .shift_clock_o(shift_clock),
    .serial_data_o(serial_data)
  );

  spl_latch_driver DUT (
    .sys_clk_i(sys_clk),
    .rstn_i(rstn),
    .shift_clock_i(shift_clock),
    .serial_data_i(serial_data),
    .latch_load_strobe_i(load),
    .output_gate_i(gate),
    .shift_stall_i(stall),
    .serial_ready_o(serial_ready),
    .serial_out_o(serial_out),
    .channel_output_o(chan)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // shift the low n bits of w, bit n-1 first, at legal spacing
  task automatic shift_in(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      host.send_bit(w[i], 13);
      exp_stage = {exp_stage[30:0], w[i]};
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_reset();
    check("chan", chan, 32'h0000_0000);
    check("cascade", {31'h0, serial_out}, 32'h0000_0000);
    check("ready", {31'h0, serial_ready}, 32'h0000_0001);
  endtask

  // full word with latches open and outputs on
  task automatic test_fill();
    @(posedge sys_clk);
    load <= 1'b1;
    gate <= 1'b1;
    shift_in(32'ha5c3_0f71, 32);
    @(negedge sys_clk);
    check("chan", chan, 32'ha5c3_0f71);
    check("cascade", {31'h0, serial_out}, 32'h0000_0001);
  endtask

  // latches closed: outputs hold while the chain keeps moving
  task automatic test_hold();
    @(posedge sys_clk);
    load <= 1'b0;
    shift_in(32'h3c00_0000, 8);
    @(negedge sys_clk);
    check("chan", chan, 32'ha5c3_0f71);
    check("cascade", {31'h0, serial_out}, {31'h0, exp_stage[31]});
  endtask

  // gate low blanks, gate high shows the newly loaded chain
  task automatic test_gate();
    @(posedge sys_clk);
    gate <= 1'b0;
    load <= 1'b1;
    shift_in(32'h9000_0000, 4);
    @(negedge sys_clk);
    check("chan", chan, 32'h0000_0000);
    check("cascade", {31'h0, serial_out}, {31'h0, exp_stage[31]});
    @(posedge sys_clk);
    gate <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check("chan", chan, exp_stage);
  endtask

  // legally spaced rises under stall: four kept, fifth refused
  task automatic test_overflow();
    int n;
    @(posedge sys_clk);
    stall <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      host.send_bit(i[0], 13); // legal spacing, the stall alone fills it
    end
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check("ready", {31'h0, serial_ready}, 32'h0000_0000);
    @(posedge sys_clk);
    stall <= 1'b0;
    n = 0;
    while (serial_ready !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 20) begin
      err_count++;
      end_of_test();
    end
    repeat (8) @(posedge sys_clk);
    exp_stage = {exp_stage[27:0], 4'h5};
    @(negedge sys_clk);
    check("chan", chan, exp_stage);
    check("cascade", {31'h0, serial_out}, {31'h0, exp_stage[31]});
  endtask

  // reset in mid-run clears everything, then one bit shifts in cleanly
  task automatic test_reset_mid();
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check("chan", chan, 32'h0000_0000);
    check("cascade", {31'h0, serial_out}, 32'h0000_0000);
    check("ready", {31'h0, serial_ready}, 32'h0000_0001);
    @(posedge sys_clk);
    rstn <= 1'b1;
    exp_stage = 32'h0000_0000;
    repeat (2) @(posedge sys_clk);
    shift_in(32'h8000_0000, 1);
    @(negedge sys_clk);
    check("chan", chan, exp_stage);
    check("cascade", {31'h0, serial_out}, {31'h0, exp_stage[31]});
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge sys_clk);
    test_reset();
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    test_fill();
    test_hold();
    test_gate();
    test_overflow();
    test_reset_mid();
    end_of_test();
  end
endmodule // spl_latch_driver_test

`default_nettype wire
